/* hscl_link.sv */
// How it works
// RQ1: Characters are start bit, eight data bits, stop bit at 38,400 baud.
// RQ2: Receive and transmit wires each carry their own independent bit stream.
// RQ3: Responses leave on our transmit line; commands arrive on receive line.
// RQ4: Only ground and data wires are needed; flow lines are optional.
// RQ5: While host clear-to-send is active, serial data on receive is taken.
// RQ6: Optionally, with clear-to-send inactive, commands come from secondary.
// RQ7: Request-to-send holds the host off until bytes can be accepted.
// RQ8: Request-to-send is driven only while a mode command has enabled it.
// RQ9: Every command and every response is exactly one byte.
// RQ10: Top three command bits select the type; low bits are payload.
// RQ11: Data commands use only the low four bits as data.
// RQ12: Address commands take the low five bits as the address.
// RQ13: Responses only report status or identify source of their data.
// RQ14: Response top bits hold source code, or echoed command when enabled.
// RQ15: Selected address is kept until the next select command or reset.
// RQ16: Read port answers with bit 4 zero and port data in bits 3..0.
// RQ17: Write port puts four data bits on the port; answers only on echo.
// RQ18: Bits sampled mid-cell by oversampling; a low stop bit is discarded.
`timescale 1ns/1ps
`include "hscl_cfg.svh"

module hscl_link
    import hscl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Serial link to the host
    input  wire logic        rxd,
    output logic             txd,
    input  wire logic        host_cts,
    output logic             rts_o,
    output logic             rts_oe,
    // Secondary controller command stream
    input  wire logic        alt_en,
    input  wire logic        sec_valid,
    input  wire logic [7:0]  sec_data,
    output logic             sec_ready,
    // Peripheral bus
    output logic [4:0]       port_addr,
    output logic [3:0]       port_dout,
    output logic             port_we,
    output logic             port_rd,
    input  wire logic [3:0]  port_din
);

    localparam logic [6:0] TICK_LAST = 7'(`HSCL_TICK_CYC - 1);
    localparam logic [7:0] WE_LAST   = 8'(`HSCL_WE_CYC - 1);

    localparam hscl_state_type ST_RST = '{
        rx_st:   RX_IDLE,
        tx_st:   TX_IDLE,
        en_st:   EN_IDLE,
        tx_sh:   10'h3ff,
        echo:    `HSCL_ECHO_RST,
        flow:    `HSCL_FLOW_RST,
        default: '0
    };

    hscl_state_type q;
    hscl_state_type d;

    logic        src_host;
    logic        rx_line;
    logic [2:0]  ctype;
    logic        tx_go;
    logic [7:0]  tx_byte;
    logic [4:0]  status;
    logic        f_in_valid;
    logic [7:0]  f_in_data;
    logic        f_in_ready;
    logic        f_out_valid;
    logic [7:0]  f_out_data;
    logic        f_out_ready;
    logic [3:0]  f_level;
    logic        ferr_set;

    // ===========================================================
    // Source selection
    // Without the option the host is always heard, so an unwired
    // clear-to-send line cannot lock the link
    assign src_host = host_cts || !alt_en; // see RQ5 see RQ4
    // Secondary stream ignores the host line completely
    assign rx_line  = src_host ? rxd : 1'b1; // see RQ6
    assign ctype    = q.cmd[7:5]; // see RQ10
    assign status   = {q.ferr, q.ovr, q.flow, q.echo, host_cts};

    // Bytes from either source share the command buffer
    assign f_in_valid = src_host ? q.rx_push : sec_valid;
    assign f_in_data  = src_host ? q.rx_byte : sec_data;
    assign sec_ready  = !src_host && f_in_ready;

    // ===========================================================
    // Command buffer
    hscl_fifo #(
        .W (`HSCL_FIFO_W),
        .D (`HSCL_FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (f_in_valid),
        .in_data   (f_in_data),
        .in_ready  (f_in_ready),
        .out_valid (f_out_valid),
        .out_data  (f_out_data),
        .out_ready (f_out_ready),
        .level     (f_level)
    );

    // ===========================================================
    // Outputs
    // Ready leaves margin for a byte the host already started
    assign rts_o     = (f_level < `HSCL_RTS_LIMIT); // see RQ7
    assign rts_oe    = q.flow; // see RQ8
    assign txd       = q.tx_sh[0]; // see RQ3
    assign port_addr = q.addr;
    assign port_dout = q.dout;
    assign port_we   = q.we;
    assign port_rd   = q.rd;

    // ===========================================================
    // Next state
    always_comb begin
        d           = q;
        d.rx_push   = 1'b0;
        d.rd        = 1'b0;
        d.tick      = 1'b0;
        tx_go       = 1'b0;
        tx_byte     = q.cmd;
        f_out_ready = 1'b0;
        ferr_set    = 1'b0;

        // Free running oversampling tick shared by both directions
        if (q.tick_cnt == TICK_LAST) begin
            d.tick_cnt = '0;
            d.tick     = 1'b1; // see RQ1
        end else begin
            d.tick_cnt = q.tick_cnt + 7'h01;
        end

        // Receiver; start edge is found to within one tick
        unique case (q.rx_st)
            RX_IDLE: begin
                if (q.tick && !rx_line) begin
                    d.rx_st  = RX_START;
                    d.rx_sub = '0;
                end
            end
            RX_START: begin
                if (q.tick) begin
                    d.rx_sub = q.rx_sub + 4'h1;
                    // A glitch shorter than half a bit is dropped
                    if (q.rx_sub == `HSCL_MID_TICK) begin
                        d.rx_sub = '0;
                        d.rx_bit = '0;
                        d.rx_st  = rx_line ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (q.tick) begin
                    d.rx_sub = q.rx_sub + 4'h1;
                    if (q.rx_sub == 4'hf) begin
                        d.rx_sh  = {rx_line, q.rx_sh[7:1]}; // see RQ18
                        d.rx_bit = q.rx_bit + 3'h1;
                        if (q.rx_bit == 3'h7) begin
                            d.rx_st = RX_STOP; // see RQ9
                        end
                    end
                end
            end
            RX_STOP: begin
                if (q.tick) begin
                    d.rx_sub = q.rx_sub + 4'h1;
                    if (q.rx_sub == 4'hf) begin
                        d.rx_st = RX_IDLE;
                        // Framing error drops the character
                        if (rx_line) begin
                            d.rx_push = 1'b1; // see RQ18
                            d.rx_byte = q.rx_sh;
                        end else begin
                            ferr_set = 1'b1; // see RQ18
                        end
                    end
                end
            end
        endcase

        // Command engine: one byte at a time, echo before answer
        unique case (q.en_st)
            EN_IDLE: begin
                f_out_ready = 1'b1;
                if (f_out_valid) begin
                    d.cmd   = f_out_data;
                    d.en_st = EN_EXEC;
                end
            end
            EN_EXEC: begin
                d.en_st     = EN_ECHO;
                d.resp_pend = 1'b1;
                unique case (ctype)
                    `HSCL_CMD_RD_PORT: begin
                        d.rd      = 1'b1;
                        d.bus_cnt = '0;
                        d.en_st   = EN_BUS;
                    end
                    `HSCL_CMD_RD_EE: begin
                        d.resp = {`HSCL_CMD_RD_EE, 1'b0, q.ee[q.addr]};
                    end
                    `HSCL_CMD_WR_PORT: begin
                        d.dout      = q.cmd[3:0]; // see RQ11
                        d.we        = 1'b1;
                        d.bus_cnt   = WE_LAST;
                        d.en_st     = EN_BUS;
                        d.resp_pend = 1'b0; // see RQ17
                    end
                    `HSCL_CMD_WR_EE: begin
                        d.ee[q.addr] = q.cmd[3:0]; // see RQ11
                        d.resp_pend  = 1'b0;
                    end
                    `HSCL_CMD_SELECT: begin
                        d.addr      = q.cmd[4:0]; // see RQ12 see RQ15
                        d.resp_pend = 1'b0;
                    end
                    `HSCL_CMD_STATUS: begin
                        d.resp = {`HSCL_CMD_STATUS, status}; // see RQ13
                        d.ferr = 1'b0;
                        d.ovr  = 1'b0;
                    end
                    `HSCL_CMD_LOOP: begin
                        d.resp = q.cmd;
                    end
                    `HSCL_CMD_MODE: begin
                        d.echo      = q.cmd[`HSCL_MODE_ECHO];
                        d.flow      = q.cmd[`HSCL_MODE_FLOW]; // see RQ8
                        d.resp_pend = 1'b0;
                    end
                endcase
            end
            EN_BUS: begin
                // Read data is taken while the read strobe is high
                if (q.rd) begin
                    d.resp = {`HSCL_CMD_RD_PORT, 1'b0, port_din}; // see RQ16
                end
                if (q.bus_cnt == '0) begin
                    d.we    = 1'b0;
                    d.en_st = EN_ECHO;
                end else begin
                    d.bus_cnt = q.bus_cnt - 8'h01;
                end
            end
            EN_ECHO: begin
                // Loopback already returns the command bits
                if (q.echo && ctype != `HSCL_CMD_LOOP) begin
                    if (q.tx_st == TX_IDLE) begin
                        tx_go   = 1'b1; // see RQ14
                        tx_byte = q.cmd;
                        d.en_st = EN_RESP;
                    end
                end else begin
                    d.en_st = EN_RESP;
                end
            end
            EN_RESP: begin
                if (!q.resp_pend) begin
                    d.en_st = EN_IDLE;
                end else if (q.tx_st == TX_IDLE) begin
                    tx_go       = 1'b1; // see RQ14
                    tx_byte     = q.resp;
                    d.resp_pend = 1'b0;
                    d.en_st     = EN_IDLE;
                end
            end
        endcase

        // Transmitter; ones shifted in behind each frame leave the line resting high in idle
        unique case (q.tx_st)
            TX_IDLE: begin
                if (tx_go) begin
                    d.tx_sh  = {1'b1, tx_byte, 1'b0}; // see RQ1
                    d.tx_sub = '0;
                    d.tx_bit = '0;
                    d.tx_st  = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (q.tick) begin
                    d.tx_sub = q.tx_sub + 4'h1;
                    if (q.tx_sub == 4'hf) begin
                        d.tx_sh  = {1'b1, q.tx_sh[9:1]}; // see RQ2
                        d.tx_bit = q.tx_bit + 4'h1;
                        if (q.tx_bit == 4'h9) begin
                            d.tx_st = TX_IDLE;
                        end
                    end
                end
            end
        endcase

        // Write pulse length, watched by the checks below
        d.we_len = q.we ? q.we_len + 8'h01 : '0;

        // Both flags are set after the status clear, so a set wins
        if (ferr_set) begin
            d.ferr = 1'b1;
        end
        if (q.rx_push && src_host && !f_in_ready) begin
            d.ovr = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // ===========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_exec(logic [2:0] t);
        q.en_st == EN_EXEC && ctype == t;
    endsequence

    sequence s_resp_load;
        tx_go && q.en_st == EN_RESP;
    endsequence

    a_tick_period: // see RQ1
    assert property (q.tick |-> ##65 q.tick)
    else $error("oversampling tick period wrong");

    a_tx_start_bit: // see RQ3
    assert property (tx_go |=> !txd ##1 !txd)
    else $error("transmit start bit missing");

    a_stop_check: // see RQ18
    assert property (q.rx_push |-> $past(rx_line)
                     && $past(q.rx_st) == RX_STOP)
    else $error("byte pushed without high stop bit");

    a_host_gate: // see RQ6
    assert property ($past(q.rx_st) == RX_IDLE && q.rx_st == RX_START
                     |-> $past(src_host))
    else $error("host start seen while host ignored");

    a_addr_hold: // see RQ15
    assert property ($changed(port_addr)
                     |-> $past(q.en_st == EN_EXEC
                               && ctype == `HSCL_CMD_SELECT))
    else $error("address changed without select");

    a_rts_enable: // see RQ8
    assert property ($changed(rts_oe)
                     |-> $past(q.en_st == EN_EXEC
                               && ctype == `HSCL_CMD_MODE))
    else $error("request-to-send enable changed");

    a_we_width: // see RQ17
    assert property ($fell(port_we) |-> q.we_len == 8'd240)
    else $error("write enable pulse width wrong");

    a_wr_data: // see RQ11
    assert property (s_exec(`HSCL_CMD_WR_PORT)
                     |=> port_we && port_dout == $past(q.cmd[3:0]))
    else $error("write data not on port");

    a_rd_resp: // see RQ16
    assert property (s_resp_load ##0 (tx_byte[7:5] == 3'h0)
                     |-> tx_byte[4] == 1'b0)
    else $error("port data response bit 4 set");

    a_resp_source: // see RQ14
    assert property (s_resp_load |-> tx_byte[7:5] == ctype)
    else $error("response source code wrong");

    a_wr_silent: // see RQ17
    assert property (s_exec(`HSCL_CMD_WR_PORT) ##1 !q.echo
                     |-> !tx_go [*8])
    else $error("write port answered without echo");

endmodule : hscl_link

/* hscl_cfg.svh */
`ifndef HSCL_CFG_SVH
`define HSCL_CFG_SVH

// ===========================================================
// Clock and link timing
`define HSCL_CLK_HZ      40000000
`define HSCL_CLK_NS      25
`define HSCL_BAUD        38400
`define HSCL_OVS         16
// Oversampling tick period, rounded down to whole cycles
`define HSCL_TICK_CYC    (`HSCL_CLK_HZ / (`HSCL_BAUD * `HSCL_OVS))
// Tick index at which a start bit is confirmed (its centre)
`define HSCL_MID_TICK    4'h7
// Peripheral write enable pulse, in ns and in cycles
`define HSCL_WE_NS       6000
`define HSCL_WE_CYC      ((`HSCL_WE_NS + `HSCL_CLK_NS - 1) / `HSCL_CLK_NS)

// ===========================================================
// Buffer sizing and flow control
`define HSCL_FIFO_W      8
`define HSCL_FIFO_D      8
// Hold the host off while two or fewer entries remain free
`define HSCL_RTS_LIMIT   4'h6

// ===========================================================
// Command and response type codes (byte bits 7..5)
`define HSCL_CMD_RD_PORT 3'h0
`define HSCL_CMD_RD_EE   3'h1
`define HSCL_CMD_WR_PORT 3'h2
`define HSCL_CMD_WR_EE   3'h3
`define HSCL_CMD_SELECT  3'h4
`define HSCL_CMD_STATUS  3'h5
`define HSCL_CMD_LOOP    3'h6
`define HSCL_CMD_MODE    3'h7

// ===========================================================
// Mode byte fields and reset values
`define HSCL_MODE_ECHO   0
`define HSCL_MODE_FLOW   1
`define HSCL_ECHO_RST    1'b0
`define HSCL_FLOW_RST    1'b0

`endif

/* hscl_pkg.sv */
package hscl_pkg;

    // ===========================================================
    // State encodings
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } hscl_rx_state_type;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } hscl_tx_state_type;

    typedef enum logic [4:0] {
        EN_IDLE = 5'b00001,
        EN_EXEC = 5'b00010,
        EN_BUS  = 5'b00100,
        EN_ECHO = 5'b01000,
        EN_RESP = 5'b10000
    } hscl_en_state_type;

    // ===========================================================
    // Whole state of the command link
    typedef struct packed {
        hscl_rx_state_type rx_st;
        logic [3:0]        rx_sub;
        logic [2:0]        rx_bit;
        logic [7:0]        rx_sh;
        logic              rx_push;
        logic [7:0]        rx_byte;
        logic [6:0]        tick_cnt;
        logic              tick;
        hscl_tx_state_type tx_st;
        logic [3:0]        tx_sub;
        logic [3:0]        tx_bit;
        logic [9:0]        tx_sh;
        hscl_en_state_type en_st;
        logic [7:0]        cmd;
        logic [7:0]        resp;
        logic              resp_pend;
        logic [7:0]        bus_cnt;
        logic [7:0]        we_len;
        logic [4:0]        addr;
        logic [3:0]        dout;
        logic              we;
        logic              rd;
        logic [31:0][3:0]  ee;
        logic              echo;
        logic              flow;
        logic              ferr;
        logic              ovr;
    } hscl_state_type;

endpackage : hscl_pkg

/* hscl_fifo.sv */
`timescale 1ns/1ps
`include "hscl_cfg.svh"

module hscl_fifo
    import hscl_pkg::*;
#(
    parameter int W = `HSCL_FIFO_W,
    parameter int D = `HSCL_FIFO_D
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           reset_n,
    // Filling side
    input  wire logic           in_valid,
    input  wire logic [W-1:0]   in_data,
    output logic                in_ready,
    // Draining side
    output logic                out_valid,
    output logic [W-1:0]        out_data,
    input  wire logic           out_ready,
    // Fill level
    output logic [$clog2(D):0]  level
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } hscl_fifo_state_type;

    hscl_fifo_state_type q;
    hscl_fifo_state_type d;
    logic                push;
    logic                pop;

    // ===========================================================
    // Handshakes straight from the count
    assign in_ready  = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign level     = q.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer wrap relies on D being a power of two
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : hscl_fifo

/* hscl_host_model.sv */
`timescale 1ns/1ps

module hscl_host_model #(
    parameter int BIT_CYC = 1040
) (
    // Clock
    input  wire logic       clk,
    // Serial lines, host side
    output logic            tx_line,
    input  wire logic       rx_line,
    // Flow control from the device
    input  wire logic       rts_o,
    input  wire logic       rts_oe,
    // Received byte strobe
    output logic            got,
    output logic [7:0]      got_byte
);
    logic [7:0] sh;

    // ==========================================================
    // Sender: one framed byte, LSB first, deferring while held off
    task automatic send(input logic [7:0] b, input logic stop_ok);
        int w;
        w = 0;
        while (rts_oe === 1'b1 && rts_o === 1'b0 && w < 200000) begin
            @(negedge clk);
            w++;
        end
        tx_line = 1'b0;
        repeat (BIT_CYC) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            tx_line = b[i];
            repeat (BIT_CYC) @(negedge clk);
        end
        // A bad stop is kept short so its tail is not a new start
        tx_line = stop_ok;
        repeat (stop_ok ? BIT_CYC : BIT_CYC * 5 / 8) @(negedge clk);
        tx_line = 1'b1;
        repeat (BIT_CYC) @(negedge clk);
    endtask : send

    // ==========================================================
    // Receiver: mid-bit sampling; a low stop reports all z
    initial begin
        tx_line = 1'b1;
        got = 1'b0;
        got_byte = 8'h00;
        forever begin
            @(negedge clk);
            got = 1'b0;
            if (rx_line === 1'b0) begin
                repeat (BIT_CYC / 2) @(negedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(negedge clk);
                    sh[i] = rx_line;
                end
                repeat (BIT_CYC) @(negedge clk);
                got_byte = (rx_line === 1'b1) ? sh : 8'hzz;
                got = 1'b1;
            end
        end
    end
endmodule : hscl_host_model

/* hscl_link_test.sv */
`timescale 1ns/1ps

module hscl_link_test;
    import hscl_pkg::*;

    // ==========================================================
    // Signals and bookkeeping
    logic        clk, reset_n, rxd, txd, host_cts, rts_o, rts_oe;
    logic        alt_en, sec_valid, sec_ready, port_we, port_rd, got;
    logic        rts_low, full_seen;
    logic [7:0]  sec_data, got_byte, loose, b;
    logic [4:0]  port_addr;
    logic [3:0]  port_dout, port_din, last_d;
    logic [7:0]  exp_q[$];
    int          error_cnt, check_count, seed, we_cnt, rd_cnt;

    hscl_link dut (.clk(clk), .reset_n(reset_n), .rxd(rxd), .txd(txd),
        .host_cts(host_cts), .rts_o(rts_o), .rts_oe(rts_oe),
        .alt_en(alt_en), .sec_valid(sec_valid), .sec_data(sec_data),
        .sec_ready(sec_ready), .port_addr(port_addr),
        .port_dout(port_dout), .port_we(port_we), .port_rd(port_rd),
        .port_din(port_din));

    hscl_host_model host (.clk(clk), .tx_line(rxd), .rx_line(txd),
        .rts_o(rts_o), .rts_oe(rts_oe), .got(got), .got_byte(got_byte));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic conclude;
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic fail(input string m);
        error_cnt++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail

    task automatic check(input logic [15:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            fail(m);
        end
    endtask : check

    // Bounded wait until every noted response has arrived
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 100000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100000) begin
            fail("response timeout");
            conclude;
        end
    endtask : drain

    // Ready is judged between edges, where it has settled
    task automatic sec_put(input logic [7:0] v);
        int n;
        n = 0;
        sec_valid = 1'b1;
        sec_data = v;
        #1;
        while (sec_ready !== 1'b1 && n < 5000) begin
            full_seen = 1'b1;
            @(negedge clk);
            #1;
            n++;
        end
        if (n >= 5000) begin
            fail("secondary stall");
            conclude;
        end
        @(negedge clk);
    endtask : sec_put

    // Oldest note against each byte the host receives, except the loose byte
    always @(posedge got) begin
        if (got_byte === loose) begin
            loose = 8'hxx;
        end else if (exp_q.size() == 0) begin
            fail("unexpected response");
        end else begin
            check(got_byte, exp_q.pop_front(), "response");
        end
    end

    // Strobe widths and hold-off seen at settled values
    always @(negedge clk) begin
        if (port_we === 1'b1) we_cnt++;
        if (port_rd === 1'b1) rd_cnt++;
        if (rts_oe === 1'b1 && rts_o === 1'b0) rts_low = 1'b1;
    end

    // ==========================================================
    // Main sequence; host traffic overlaps responses to save time
    initial begin
        seed = 3;
        {error_cnt, check_count, we_cnt, rd_cnt} = '0;
        {rts_low, full_seen} = 2'b00;
        loose = 8'hxx;
        reset_n = 1'b0;
        host_cts = 1'b1;
        alt_en = 1'b1;
        sec_valid = 1'b0;
        sec_data = 8'h00;
        port_din = 4'h0;
        repeat (2) @(negedge clk);
        check({txd, rts_oe, port_we, port_rd, port_addr}, 16'h100, "reset");
        reset_n = 1'b1;
        host.send(8'h9b, 1'b1);
        check(port_addr, 16'h1b, "select");
        port_din = 4'($random(seed));
        exp_q.push_back({4'h0, port_din});
        host.send(8'h1f, 1'b1);
        host.send(8'he2, 1'b1);
        check(rts_oe, 16'h1, "flow enable");
        host.send(8'h42, 1'b0);
        exp_q.push_back(8'hb5);
        exp_q.push_back(8'ha5);
        host.send(8'ha0, 1'b1);
        host.send(8'ha0, 1'b1);
        drain;
        check(we_cnt, 16'h0, "bad frame");
        // Secondary stream floods the buffer with long writes
        host_cts = 1'b0;
        for (int k = 0; k < 12; k++) begin
            b = {3'b010, 5'($random(seed))};
            last_d = b[3:0];
            sec_put(b);
        end
        sec_put(8'h79);
        exp_q.push_back(8'h29);
        sec_put(8'h20);
        b = {3'b110, 5'($random(seed))};
        exp_q.push_back(b);
        sec_put(b);
        loose = 8'he3;
        sec_put(8'he3);
        port_din = 4'($random(seed));
        exp_q.push_back(8'h07);
        exp_q.push_back({4'h0, port_din});
        sec_put(8'h07);
        exp_q.push_back(8'h83);
        sec_put(8'h83);
        sec_valid = 1'b0;
        drain;
        check(we_cnt, 16'd2880, "write pulses");
        check(port_dout, last_d, "write data");
        check(rd_cnt, 16'h2, "read strobes");
        check(port_addr, 16'h03, "kept address");
        check({full_seen, rts_low}, 16'h3, "hold off");
        conclude;
    end
endmodule : hscl_link_test
